// ---- verilog/timer_map.svh ----
// Operation
// - Software picks no clock, bus clock, fixed clock or external clock for prescaler.
// - External clock input is synchronised to the bus clock before use.
// - With external clock selected, a channel still works as software compare timer.
// - Pin stays with general I/O when edge/level select or clock select is zero.
// - Center-aligned select with nonzero edge/level makes channels center PWM drivers.
// - Otherwise mode bits pick capture, compare or edge-aligned PWM.
// - Capture makes the pin an edge input; edge/level picks the edges.
// - Capture edges are synchronised; four-cycle pulses are always seen.
// - Compare drives the pin and toggles, clears or sets it on match.
// - Entering toggle mode keeps the prior pin level until the next match.
// - Edge PWM 1:0 goes high at count zero, low on match.
// - Edge PWM low bit set goes low at count zero, high on match.
// - Center PWM 1:0 clears on up-count match, sets on down-count match.
// - Center PWM low bit set sets on up-count match, clears on down match.
// - Overflow flag, bit 7, sets when counter wraps to zero; reset clears.
// - Flag clears by read while set then write of 0; writing 1 ignored.
// - Overflow during clear sequence restarts it so the flag stays set.
// - Overflow interrupt enable, bit 6, requests interrupt while flag is one.
// - Center-aligned select, bit 5, makes the counter count up and down.
// - Clock select in bits 4-3; fixed clock arrives synchronised to bus clock.
// - Prescale in bits 2-0 picks eight divisors, effective next cycle.
// - Clock select codes: 00 off, 01 bus, 10 fixed, 11 external.
// - Prescale codes 000 to 111 divide by 1 through 128.
// - Up-counting counter restarts at zero after modulo and sets the flag.
// - Center mode counts up to modulo then down to zero repeatedly.
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH
`define ADDR_STATUS_CONTROL  12'h000
`define ADDR_COUNTER         12'h004
`define ADDR_MODULO          12'h008
`define ADDR_CHAN_CONTROL    12'h010
`define ADDR_CHAN_VALUE      12'h014
`define CHAN_STRIDE          12'h008
`define BIT_OVF              7
`define BIT_OVIE             6
`define BIT_CENTER           5
`define CLKSEL_OFF           2'h0
`define CLKSEL_BUS           2'h1
`define CLKSEL_FIXED         2'h2
`define CLKSEL_EXT           2'h3
`define ELS_NONE             2'h0
`define ELS_A                2'h1
`define ELS_B                2'h2
`define ELS_BOTH             2'h3
`define CH_BIT_FLAG          7
`define COUNT_ZERO           16'h0000
`define HTRANS_NONSEQ        2'h2
`endif

// ---- verilog/timer_pkg.sv ----
package timer_pkg;
  typedef struct packed {
    logic       overflowFlag;
    logic       overflowIrqEnable;
    logic       centerAlignedSelect;
    logic [1:0] clockSourceSelect;
    logic [2:0] prescaleSelect;
  } status_control_type;

  typedef struct packed {
    logic       chanFlag;
    logic [1:0] channelModeSelect;
    logic [1:0] edgeLevelSelect;
  } chan_control_type;

  typedef enum logic [1:0] {
    FUNC_OFF     = 2'b00,
    FUNC_CAPTURE = 2'b01,
    FUNC_COMPARE = 2'b10,
    FUNC_PWM     = 2'b11
  } chan_func_type;

  typedef enum logic [1:0] {
    CLR_IDLE  = 2'b00,
    CLR_ARMED = 2'b01
  } clear_state_type;
endpackage

// ---- verilog/timer_channel.sv ----
`timescale 1ns/1ps
`include "timer_map.svh"
module timer_channel
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // Configuration
  input  wire chan_control_type control,
  input  wire logic [15:0]      chanValue,
  input  wire logic             centerAligned,
  input  wire logic             timerOn,
  // Counter timing
  input  wire logic [15:0]      counterValue,
  input  wire logic             countTick,
  input  wire logic             countingDown,
  // Pin
  input  wire logic             pinIn,
  output logic                  pinOut,
  output logic                  pinOe,
  // Events
  output logic                  captureEvent,
  output logic                  matchEvent
);
  // ==========================================================
  // Function decode
  logic          syncA;
  logic          syncB;
  logic          syncC;
  logic          driveLevel;
  logic          driveLevelNext;
  wire  logic    elsOn     = control.edgeLevelSelect != `ELS_NONE;
  wire  logic    active    = elsOn && timerOn;
  wire  logic    isCenter  = active && centerAligned;
  wire  logic    isCapture = active && !centerAligned && control.channelModeSelect == 2'b00;
  wire  logic    isCompare = active && !centerAligned && control.channelModeSelect == 2'b01;
  wire  logic    isEdgePwm = active && !centerAligned && control.channelModeSelect[1];
  wire  logic    matchHit  = countTick && counterValue == chanValue;
  wire  logic    periodStart = countTick && counterValue == `COUNT_ZERO;
  wire  logic    riseSeen  = syncB && !syncC;
  wire  logic    fallSeen  = !syncB && syncC;
  wire  logic    lowBit    = control.edgeLevelSelect[0];

  // ==========================================================
  // Capture synchroniser; only syncB and syncC feed the edge test
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncC <= 1'b0;
    end else begin
      syncA <= pinIn;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  // ==========================================================
  // Pin level; compare with select 0:0 still flags matches for software timing
  always_comb begin
    driveLevelNext = driveLevel;
    if (isCompare && matchHit) begin
      case (control.edgeLevelSelect)
        `ELS_A:  driveLevelNext = !driveLevel;
        `ELS_B:  driveLevelNext = 1'b0;
        default: driveLevelNext = 1'b1;
      endcase
    end else if (isEdgePwm) begin
      if (matchHit) begin
        driveLevelNext = lowBit;
      end else if (periodStart) begin
        driveLevelNext = !lowBit;
      end
    end else if (isCenter && matchHit) begin
      driveLevelNext = countingDown ? !lowBit : lowBit;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      driveLevel   <= 1'b0;
      pinOut       <= 1'b0;
      pinOe        <= 1'b0;
      captureEvent <= 1'b0;
      matchEvent   <= 1'b0;
    end else begin
      driveLevel   <= driveLevelNext;
      pinOut       <= driveLevelNext;
      pinOe        <= isCompare || isEdgePwm || isCenter;
      captureEvent <= isCapture && ((riseSeen && control.edgeLevelSelect[0])
                      || (fallSeen && control.edgeLevelSelect[1]));
      matchEvent   <= timerOn && !centerAligned
                      && control.channelModeSelect == 2'b01 && matchHit;
    end
  end
endmodule

// ---- verilog/timer_top.sv ----
`timescale 1ns/1ps
`include "timer_map.svh"
module timer_top
  import timer_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [11:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Clock sources
  input  wire logic                fixedClockTick,
  input  wire logic                externalClockInput,
  // Channel pins
  input  wire logic [CHANNELS-1:0] channelPinIn,
  output logic [CHANNELS-1:0]      channelPinOut,
  output logic [CHANNELS-1:0]      channelPinOe,
  // Interrupts
  output logic                     overflowIrq,
  output logic [CHANNELS-1:0]      channelIrq
);
  // ==========================================================
  // State
  status_control_type statusControl_reg;
  clear_state_type    clearState_reg;
  chan_control_type   chanControl_reg [CHANNELS];
  logic [15:0]        chanValue_reg [CHANNELS];
  logic [CHANNELS-1:0] chanIrqEn_reg;
  logic [15:0]        counter_reg;
  logic [15:0]        modulo_reg;
  logic               down_reg;
  logic [6:0]         prescale_reg;
  logic               extSyncA;
  logic               extSyncB;
  logic               extSyncC;
  logic               fixedSync_reg;
  logic               wrPend_reg;
  logic               rdPend_reg;
  logic [11:0]        addrPend_reg;
  logic [CHANNELS-1:0] captureEvent;
  logic [CHANNELS-1:0] matchEvent;
  logic [31:0]        readData;

  // ==========================================================
  // Clock source and prescaler
  wire logic extRise = extSyncB && !extSyncC;
  wire logic timerOn = statusControl_reg.clockSourceSelect != `CLKSEL_OFF;
  wire logic srcTick =
    (statusControl_reg.clockSourceSelect == `CLKSEL_BUS)   ? 1'b1 :
    (statusControl_reg.clockSourceSelect == `CLKSEL_FIXED) ? fixedSync_reg :
    (statusControl_reg.clockSourceSelect == `CLKSEL_EXT)   ? extRise : 1'b0;
  wire logic [6:0] divMask = 7'((8'h01 << statusControl_reg.prescaleSelect) - 8'h01);
  wire logic countTick = srcTick && ((prescale_reg & divMask) == divMask);
  wire logic atTop = (modulo_reg == `COUNT_ZERO) ? (counter_reg == 16'hFFFF)
                                                 : (counter_reg == modulo_reg);
  wire logic center = statusControl_reg.centerAlignedSelect;
  wire logic overflowEvent = countTick && (center ? (down_reg && counter_reg == 16'h0001)
                                                  : atTop);

  // ==========================================================
  // Bus decode
  wire logic addrTake = hsel && hready && htrans == `HTRANS_NONSEQ;
  wire logic wrScReg  = wrPend_reg && addrPend_reg == `ADDR_STATUS_CONTROL;
  wire logic wrCnt    = wrPend_reg && addrPend_reg == `ADDR_COUNTER;
  wire logic wrMod    = wrPend_reg && addrPend_reg == `ADDR_MODULO;
  wire logic rdScFlag = addrTake && !hwrite && haddr == `ADDR_STATUS_CONTROL
                        && statusControl_reg.overflowFlag;
  wire logic [11:0] chanOff = addrPend_reg - `ADDR_CHAN_CONTROL;
  wire logic [11:0] chanIdx = chanOff / `CHAN_STRIDE;
  wire logic chanHit = addrPend_reg >= `ADDR_CHAN_CONTROL
                       && chanIdx < 12'(CHANNELS);
  wire logic chanValSel = chanOff[2];
  // Reads decode in the address phase so the registered word stands in the data phase
  wire logic [11:0] rdAddr    = {haddr[11:2], 2'b00};
  wire logic [11:0] rdOff     = rdAddr - `ADDR_CHAN_CONTROL;
  wire logic [11:0] rdIdx     = rdOff / `CHAN_STRIDE;
  wire logic        rdChanHit = rdAddr >= `ADDR_CHAN_CONTROL && rdIdx < 12'(CHANNELS);

  always_comb begin
    readData = 32'h0000_0000;
    if (rdAddr == `ADDR_STATUS_CONTROL) begin
      readData = {24'h000000, statusControl_reg};
    end else if (rdAddr == `ADDR_COUNTER) begin
      readData = {16'h0000, counter_reg};
    end else if (rdAddr == `ADDR_MODULO) begin
      readData = {16'h0000, modulo_reg};
    end else if (rdChanHit && rdOff[2]) begin
      readData = {16'h0000, chanValue_reg[rdIdx[2:0]]};
    end else if (rdChanHit) begin
      readData = {24'h000000, chanControl_reg[rdIdx[2:0]].chanFlag,
                  chanIrqEn_reg[rdIdx[2:0]], 1'b0,
                  chanControl_reg[rdIdx[2:0]].channelModeSelect,
                  chanControl_reg[rdIdx[2:0]].edgeLevelSelect, 1'b0};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrPend_reg   <= 1'b0;
      rdPend_reg   <= 1'b0;
      addrPend_reg <= 12'h000;
      hrdata       <= 32'h0000_0000;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end else begin
      wrPend_reg   <= addrTake && hwrite;
      rdPend_reg   <= addrTake && !hwrite;
      addrPend_reg <= addrTake ? {haddr[11:2], 2'b00} : addrPend_reg;
      hrdata       <= (addrTake && !hwrite) ? readData : 32'h0000_0000;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end
  end

  // ==========================================================
  // Status/control with overflow clear sequence
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      statusControl_reg <= '0;
      clearState_reg    <= CLR_IDLE;
    end else begin
      if (wrScReg) begin
        statusControl_reg.overflowIrqEnable   <= hwdata[`BIT_OVIE];
        statusControl_reg.centerAlignedSelect <= hwdata[`BIT_CENTER];
        statusControl_reg.clockSourceSelect   <= hwdata[4:3];
        statusControl_reg.prescaleSelect      <= hwdata[2:0];
      end
      if (overflowEvent) begin
        statusControl_reg.overflowFlag <= 1'b1;
      end else if (wrScReg && !hwdata[`BIT_OVF] && clearState_reg == CLR_ARMED) begin
        statusControl_reg.overflowFlag <= 1'b0;
      end
      case (clearState_reg)
        CLR_IDLE:  clearState_reg <= rdScFlag ? CLR_ARMED : CLR_IDLE;
        CLR_ARMED: clearState_reg <= (overflowEvent || wrScReg) ? CLR_IDLE : CLR_ARMED;
        default:   clearState_reg <= CLR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Counter, prescaler, synchronisers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      counter_reg   <= `COUNT_ZERO;
      modulo_reg    <= `COUNT_ZERO;
      down_reg      <= 1'b0;
      prescale_reg  <= 7'h00;
      extSyncA      <= 1'b0;
      extSyncB      <= 1'b0;
      extSyncC      <= 1'b0;
      fixedSync_reg <= 1'b0;
      overflowIrq   <= 1'b0;
    end else begin
      extSyncA      <= externalClockInput;
      extSyncB      <= extSyncA;
      extSyncC      <= extSyncB;
      fixedSync_reg <= fixedClockTick;
      overflowIrq   <= statusControl_reg.overflowIrqEnable
                       && statusControl_reg.overflowFlag;
      if (wrMod) begin
        modulo_reg <= hwdata[15:0];
      end
      if (wrCnt || wrScReg) begin
        prescale_reg <= 7'h00;
      end else if (srcTick) begin
        prescale_reg <= prescale_reg + 7'h01;
      end
      if (wrCnt) begin
        counter_reg <= `COUNT_ZERO;
        down_reg    <= 1'b0;
      end else if (countTick && center) begin
        if (!down_reg && atTop) begin
          down_reg    <= 1'b1;
          counter_reg <= counter_reg - 16'h0001;
        end else if (down_reg && counter_reg == 16'h0001) begin
          down_reg    <= 1'b0;
          counter_reg <= `COUNT_ZERO;
        end else begin
          counter_reg <= down_reg ? counter_reg - 16'h0001 : counter_reg + 16'h0001;
        end
      end else if (countTick) begin
        down_reg    <= 1'b0;
        counter_reg <= atTop ? `COUNT_ZERO : counter_reg + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Channels
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chanIrqEn_reg <= '0;
      channelIrq    <= '0;
      for (int i = 0; i < CHANNELS; i++) begin
        chanControl_reg[i] <= '0;
        chanValue_reg[i]   <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        channelIrq[i] <= chanIrqEn_reg[i] && chanControl_reg[i].chanFlag;
        if (wrPend_reg && chanHit && chanIdx == 12'(i) && !chanValSel) begin
          chanIrqEn_reg[i]                     <= hwdata[6];
          chanControl_reg[i].channelModeSelect <= hwdata[5:4];
          chanControl_reg[i].edgeLevelSelect   <= hwdata[3:2];
        end
        if (captureEvent[i] || matchEvent[i]) begin
          chanControl_reg[i].chanFlag <= 1'b1;
        end else if (wrPend_reg && chanHit && chanIdx == 12'(i) && !chanValSel
                     && !hwdata[`CH_BIT_FLAG]) begin
          chanControl_reg[i].chanFlag <= 1'b0;
        end
        if (captureEvent[i]) begin
          chanValue_reg[i] <= counter_reg;
        end else if (wrPend_reg && chanHit && chanIdx == 12'(i) && chanValSel) begin
          chanValue_reg[i] <= hwdata[15:0];
        end
      end
    end
  end

  for (genvar g = 0; g < CHANNELS; g++) begin : gChan
    timer_channel chan (
      .clk_sys      (clk_sys),
      .rstn         (rstn),
      .control      (chanControl_reg[g]),
      .chanValue    (chanValue_reg[g]),
      .centerAligned(center),
      .timerOn      (timerOn),
      .counterValue (counter_reg),
      .countTick    (countTick),
      .countingDown (down_reg),
      .pinIn        (channelPinIn[g]),
      .pinOut       (channelPinOut[g]),
      .pinOe        (channelPinOe[g]),
      .captureEvent (captureEvent[g]),
      .matchEvent   (matchEvent[g])
    );
  end
endmodule

// ---- testbench/timer_checker_properties.sv ----
`timescale 1ns/1ps
module timer_checker
  import timer_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                rstn,
  // Bus
  input wire logic                hsel,
  input wire logic [11:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [2:0]          hsize,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  // Sources and pins
  input wire logic                fixedClockTick,
  input wire logic                externalClockInput,
  input wire logic [CHANNELS-1:0] channelPinIn,
  input wire logic [CHANNELS-1:0] channelPinOut,
  input wire logic [CHANNELS-1:0] channelPinOe,
  input wire logic                overflowIrq,
  input wire logic [CHANNELS-1:0] channelIrq
);
  // ==========================================================
  // Shadow of the bus writes
  logic        dpOn;
  logic        dpWr;
  logic [11:0] dpAddr;
  logic [6:0]  scShadow;
  logic [3:0]  chShadow;
  wire         wrSc   = dpOn && dpWr && dpAddr == 12'h000;
  wire         rdSc   = dpOn && !dpWr && dpAddr == 12'h000;
  // Channel 0 owns its pin only with a clock, an edge setting and a non-capture use
  wire         expOe0 = scShadow[4:3] != 2'h0 && chShadow[1:0] != 2'h0
                        && (scShadow[5] || chShadow[3:2] != 2'h0);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dpOn     <= 1'b0;
      dpWr     <= 1'b0;
      dpAddr   <= 12'h000;
      scShadow <= 7'h00;
      chShadow <= 4'h0;
    end else begin
      dpOn   <= hsel && hready && htrans == 2'h2;
      dpWr   <= hwrite;
      dpAddr <= haddr;
      if (wrSc) scShadow <= hwdata[6:0];
      if (dpOn && dpWr && dpAddr == 12'h010) chShadow <= hwdata[5:2];
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_unmapped_zero: assert property (dpOn && !dpWr && dpAddr >= 12'h050 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_readback: assert property (rdSc |-> hrdata[6:0] == scShadow && hrdata[31:8] == 24'h0)
    else $error("status control readback wrong");
  a_pin_owner: assert property (expOe0 == $past(expOe0) |-> channelPinOe[0] == expOe0)
    else $error("pin enable wrong for mode");
  a_irq_needs_enable: assert property (!scShadow[6] && !$past(scShadow[6]) |-> !overflowIrq)
    else $error("overflow irq without enable");
  a_irq_clear_write: assert property ($fell(overflowIrq) |-> $past(wrSc) || $past(wrSc, 2))
    else $error("overflow irq dropped without write");
  a_reset_quiet: assert property ($rose(rstn) |-> channelPinOe == '0 && !overflowIrq)
    else $error("outputs active after reset");
endmodule

bind timer_top timer_checker #(.CHANNELS(CHANNELS)) checker0 (
  .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .fixedClockTick(fixedClockTick),
  .externalClockInput(externalClockInput), .channelPinIn(channelPinIn),
  .channelPinOut(channelPinOut), .channelPinOe(channelPinOe),
  .overflowIrq(overflowIrq), .channelIrq(channelIrq)
);

// ---- testbench/pin_partner.sv ----
`timescale 1ns/1ps
module pin_partner (
  // Clock
  input  wire logic       clk_sys,
  // Pins
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  input  wire logic [7:0] stimLevel,
  output logic      [7:0] pinLevel,
  // Clock sources
  input  wire logic       extRun,
  output logic            extClock  = 1'b0,
  output logic            fixedTick = 1'b0
);
  logic [2:0] phase = 3'h0;
  // The timer wins where it drives; elsewhere the far side sets the level
  assign pinLevel = (pinOe & pinOut) | (~pinOe & stimLevel);
  always @(posedge clk_sys) begin
    phase <= phase + 3'h1;
    // One eighth of the bus rate leaves margin for the synchronizer
    extClock  <= extRun && phase[2];
    fixedTick <= phase[1:0] == 2'h3;
  end
endmodule

// ---- testbench/timer_channel_pin_and_status_control_tb.sv ----
`timescale 1ns/1ps
module timer_channel_pin_and_status_control_tb;
  import timer_pkg::*;
  logic        clk_sys = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, extRun = 1'b0;
  logic [11:0] haddr   = 12'h000;
  logic [1:0]  htrans  = 2'h0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0, hrdata, rd;
  logic        hreadyout, hresp, overflowIrq, fixedClockTick, externalClockInput;
  logic [7:0]  channelPinIn, channelPinOut, channelPinOe, channelIrq, stimLevel = 8'h00;
  int          num_errors = 0, n_tests = 0, c;
  always #2.5 clk_sys = ~clk_sys;
  timer_top #(.CHANNELS(8)) dut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fixedClockTick(fixedClockTick),
    .externalClockInput(externalClockInput), .channelPinIn(channelPinIn),
    .channelPinOut(channelPinOut), .channelPinOe(channelPinOe), .overflowIrq(overflowIrq),
    .channelIrq(channelIrq));
  pin_partner farSide (.clk_sys(clk_sys), .pinOut(channelPinOut), .pinOe(channelPinOe),
    .stimLevel(stimLevel), .pinLevel(channelPinIn), .extRun(extRun),
    .extClock(externalClockInput), .fixedTick(fixedClockTick));
  // ==========================================================
  // Shared tasks
  task print_verdict;
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task chkNear(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if ((got + 3 >= exp && got <= exp + 3) !== 1'b1) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Each phase holds until hready is seen high at a rising edge; read data taken there
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int i;
    i = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(posedge clk_sys);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk_sys);
      i++;
    end while (hreadyout !== 1'b1 && i < 100);
    rd = hrdata;
    if (i >= 100) begin
      num_errors++;
      print_verdict;
    end
  endtask
  task waitPin(input logic v);
    int i;
    i = 0;
    do begin
      @(negedge clk_sys);
      i++;
    end while (channelPinOut[0] !== v && i < 40);
    @(posedge clk_sys);
    chk("pin level", v, channelPinOut[0]);
  endtask
  // ==========================================================
  // Scenarios
  task tReset;
    xfer(12'h000, 1'b0, 32'h0);
    chk("status after reset", 32'h0, rd);
    xfer(12'h0FC, 1'b1, 32'hFFFFFFFF);
    xfer(12'h0FC, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task tOverflow;
    xfer(12'h008, 1'b1, 32'h1);
    xfer(12'h004, 1'b1, 32'h0);
    xfer(12'h000, 1'b1, 32'h4F);
    c = 0;
    while (overflowIrq !== 1'b1 && c < 600) begin
      @(posedge clk_sys);
      c++;
    end
    chkNear("overflow delay", 32'd256, c);
    xfer(12'h000, 1'b0, 32'h0);
    chk("flag set", 32'hCF, rd);
    xfer(12'h000, 1'b1, 32'hCF);
    xfer(12'h000, 1'b0, 32'h0);
    chk("flag after write one", 32'hCF, rd);
    repeat (300) @(posedge clk_sys);
    xfer(12'h000, 1'b1, 32'h4F);
    xfer(12'h000, 1'b0, 32'h0);
    chk("flag rearmed", 32'hCF, rd);
    xfer(12'h000, 1'b1, 32'h4F);
    xfer(12'h000, 1'b0, 32'h0);
    chk("flag cleared", 32'h4F, rd);
    chk("irq cleared", 32'h0, overflowIrq);
  endtask
  task tCompare;
    xfer(12'h008, 1'b1, 32'hF);
    xfer(12'h014, 1'b1, 32'h5);
    xfer(12'h000, 1'b1, 32'h08);
    xfer(12'h010, 1'b1, 32'h1C);
    waitPin(1'b1);
    xfer(12'h010, 1'b1, 32'h18);
    waitPin(1'b0);
    xfer(12'h010, 1'b1, 32'h14);
    waitPin(1'b1);
    waitPin(1'b0);
  endtask
  task automatic tPwm;
    logic [7:0] ctl[4] = '{8'h28, 8'h24, 8'h08, 8'h04};
    int         hi[4]  = '{5, 11, 10, 20};
    for (int k = 0; k < 4; k++) begin
      xfer(12'h000, 1'b1, k < 2 ? 32'h08 : 32'h28);
      xfer(12'h010, 1'b1, {24'h0, ctl[k]});
      repeat (40) @(posedge clk_sys);
      c = 0;
      repeat (k < 2 ? 16 : 30) begin
        @(negedge clk_sys);
        c += (channelPinOut[0] === 1'b1);
      end
      @(posedge clk_sys);
      chk("pwm high cycles", hi[k], c);
    end
  endtask
  task tCapture;
    xfer(12'h000, 1'b1, 32'h08);
    xfer(12'h010, 1'b1, 32'h0);
    repeat (8) @(posedge clk_sys);
    for (int e = 1; e < 4; e++) begin
      xfer(12'h010, 1'b1, e << 2);
      stimLevel[0] <= 1'b1;
      // Eight-cycle pulses stay above the shortest pulse that is surely seen
      repeat (8) @(posedge clk_sys);
      xfer(12'h010, 1'b0, 32'h0);
      chk("rising capture", e & 1, rd[7]);
      xfer(12'h010, 1'b1, e << 2);
      stimLevel[0] <= 1'b0;
      repeat (8) @(posedge clk_sys);
      xfer(12'h010, 1'b0, 32'h0);
      chk("falling capture", e >> 1, rd[7]);
    end
  endtask
  task automatic tClocks;
    logic [7:0] sc[5]  = '{8'h08, 8'h0B, 8'h10, 8'h18, 8'h00};
    int         cnt[5] = '{80, 10, 20, 10, 0};
    extRun <= 1'b1;
    xfer(12'h008, 1'b1, 32'h0);
    // Capture left an arbitrary count in the channel value
    xfer(12'h014, 1'b1, 32'h5);
    for (int k = 0; k < 5; k++) begin
      xfer(12'h000, 1'b1, {24'h0, sc[k]});
      xfer(12'h010, 1'b1, 32'h50);
      xfer(12'h004, 1'b1, 32'h0);
      repeat (80) @(posedge clk_sys);
      xfer(12'h004, 1'b0, 32'h0);
      chkNear("count rate", cnt[k], rd);
      chk("software timer match", cnt[k] > 5, channelIrq[0]);
    end
    extRun <= 1'b0;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    tReset;
    tOverflow;
    tCompare;
    tPwm;
    tCapture;
    tClocks;
    print_verdict;
  end
  initial begin
    #500000;
    num_errors++;
    print_verdict;
  end
endmodule
